// ===== shared/zv_pkg.sv
// Constants, register map and carrier types for the zoomed-video port control
`default_nettype none
package zv_pkg;

  localparam int NUM_SOCKETS = 2;
  localparam int CARD_ADDR_W = 26;
  localparam int LOW_ADDR_W = 4;
  localparam int OFFSET_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_EN_W = 4;

  // Socket register space, one block per socket
  localparam logic [7:0] OFF_PRESENT_STATE = 8'h08;
  localparam logic [7:0] OFF_FORCE_EVENT = 8'h0C;
  localparam logic [7:0] OFF_SOCKET_CONTROL = 8'h10;

  // Configuration space, two bytes per socket function
  localparam logic [7:0] OFF_CARD_CONTROL = 8'h91;
  localparam logic [7:0] OFF_DIAGNOSTIC = 8'h93;

  // Field positions
  localparam int BIT_PLATFORM_SUPPORT = 27;
  localparam int BIT_FORCE_SUPPORT = 27;
  localparam int BIT_IN_USE = 11;
  localparam int BIT_MODEL_CAPABLE = 10;
  localparam int BIT_SOCKET_ENABLE = 9;
  localparam int BIT_LEGACY_ENABLE = 6;
  localparam int BIT_PRIORITY = 5;
  localparam int BIT_MODEL_DISABLE = 0;

  // Reset values and the model-capable parameter default
  localparam logic [7:0] CARD_CONTROL_RESET = 8'h00;
  localparam logic [7:0] DIAGNOSTIC_RESET = 8'h00;
  localparam logic SUPPORT_FLAG_RESET = 1'b0;
  localparam logic SOCKET_ENABLE_RESET = 1'b0;
  localparam logic MODEL_CAPABLE_DEFAULT = 1'b1;

  typedef enum logic {
    SPACE_CONFIG,
    SPACE_SOCKET
  } space_e;

  typedef struct packed {
    logic write;
    logic read;
    space_e space;
    logic socket;
    logic [OFFSET_W-1:0] offset;
    logic [DATA_W-1:0] wdata;
    logic [BYTE_EN_W-1:0] byte_en;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } reg_rsp_s;

endpackage
`default_nettype wire

// ===== src/video_select_decode.sv
// Socket select and status decode for the video port
`default_nettype none
module video_select_decode (
  input wire logic [1:0] enable,
  input wire logic prefer_socket1,
  output logic select0_n,
  output logic select1_n,
  output logic active
);

  logic pick0;
  logic pick1;

  // Priority between two enabled sockets
  always_comb begin
    pick0 = 1'b0;
    pick1 = 1'b0;
    if (prefer_socket1) begin
      pick1 = enable[1];
      pick0 = enable[0] & ~enable[1];
    end else begin
      pick0 = enable[0];
      pick1 = enable[1] & ~enable[0];
    end
  end

  assign select0_n = ~pick0;
  assign select1_n = ~pick1;
  assign active = pick0 | pick1;

endmodule
`default_nettype wire

// ===== src/zoomed_video_port_control.sv
// Zoomed-video port control: enables, selects, address tri-state, registers
`default_nettype none
module zoomed_video_port_control #(
  parameter int NUM_SOCKETS = zv_pkg::NUM_SOCKETS,
  parameter int CARD_ADDR_W = zv_pkg::CARD_ADDR_W,
  parameter int LOW_ADDR_W = zv_pkg::LOW_ADDR_W,
  parameter logic MODEL_CAPABLE = zv_pkg::MODEL_CAPABLE_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire zv_pkg::reg_req_s reg_req,
  output zv_pkg::reg_rsp_s reg_rsp,
  input wire logic [NUM_SOCKETS-1:0][CARD_ADDR_W-1:0] core_addr,
  input wire logic [NUM_SOCKETS-1:0] core_addr_drive,
  output logic [NUM_SOCKETS-1:0][CARD_ADDR_W-1:0] card_addr_out,
  output logic [NUM_SOCKETS-1:0] card_addr_hi_oe,
  output logic [NUM_SOCKETS-1:0] card_addr_lo_oe,
  output logic socket0_video_select_n,
  output logic socket1_video_select_n,
  output logic video_port_active_out
);

  logic [NUM_SOCKETS-1:0][7:0] card_control_reg;
  logic [NUM_SOCKETS-1:0][7:0] diagnostic_control_reg;
  logic [NUM_SOCKETS-1:0] platform_video_support_flag;
  logic [NUM_SOCKETS-1:0] socket_video_port_enable;
  logic [NUM_SOCKETS-1:0] legacy_video_port_enable;
  logic [NUM_SOCKETS-1:0] standard_video_model_disable;
  logic [NUM_SOCKETS-1:0] effective_enable;
  logic [NUM_SOCKETS-1:0] standard_video_model_capable;
  logic video_port_in_use;
  logic prefer_socket1;

  logic [NUM_SOCKETS-1:0] sel_cfg;
  logic [NUM_SOCKETS-1:0] sel_sock;
  logic cfg_write;
  logic sock_write;
  logic cfg_card_control_hit;
  logic cfg_diagnostic_hit;
  logic sock_present_hit;
  logic sock_force_hit;
  logic sock_control_hit;

  logic [zv_pkg::DATA_W-1:0] rdata_next;
  logic rvalid_next;

  logic decode_select0_n;
  logic decode_select1_n;
  logic decode_active;

  // Request decode
  assign cfg_write = reg_req.write & (reg_req.space == zv_pkg::SPACE_CONFIG);
  assign sock_write = reg_req.write &
                      (reg_req.space == zv_pkg::SPACE_SOCKET);
  assign cfg_card_control_hit = reg_req.offset == zv_pkg::OFF_CARD_CONTROL;
  assign cfg_diagnostic_hit = reg_req.offset == zv_pkg::OFF_DIAGNOSTIC;
  assign sock_present_hit = reg_req.offset == zv_pkg::OFF_PRESENT_STATE;
  assign sock_force_hit = reg_req.offset == zv_pkg::OFF_FORCE_EVENT;
  assign sock_control_hit = reg_req.offset == zv_pkg::OFF_SOCKET_CONTROL;

  // Socket priority is taken from the socket 0 function
  assign prefer_socket1 = card_control_reg[0][zv_pkg::BIT_PRIORITY];

  generate
    for (genvar s = 0; s < NUM_SOCKETS; s++) begin : g_socket
      assign sel_cfg[s] = cfg_write & (reg_req.socket == 1'(s)) &
                          reg_req.byte_en[0];
      assign sel_sock[s] = sock_write & (reg_req.socket == 1'(s));

      assign legacy_video_port_enable[s] =
        card_control_reg[s][zv_pkg::BIT_LEGACY_ENABLE];
      assign standard_video_model_disable[s] =
        diagnostic_control_reg[s][zv_pkg::BIT_MODEL_DISABLE];
      assign standard_video_model_capable[s] =
        MODEL_CAPABLE & ~standard_video_model_disable[s];
      assign effective_enable[s] = legacy_video_port_enable[s] |
        (socket_video_port_enable[s] &
         ~standard_video_model_disable[s]);

      // Card control byte per socket function
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          card_control_reg[s] <= zv_pkg::CARD_CONTROL_RESET;
        end else if (clk_en && sel_cfg[s] && cfg_card_control_hit) begin
          card_control_reg[s] <= reg_req.wdata[7:0];
        end
      end

      // Diagnostic byte per socket function
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          diagnostic_control_reg[s] <= zv_pkg::DIAGNOSTIC_RESET;
        end else if (clk_en && sel_cfg[s] && cfg_diagnostic_hit) begin
          diagnostic_control_reg[s] <= reg_req.wdata[7:0];
        end
      end

      // Platform support flag, set only through force event
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          platform_video_support_flag[s] <= zv_pkg::SUPPORT_FLAG_RESET;
        end else if (clk_en && sel_sock[s] && sock_force_hit &&
                     reg_req.byte_en[3] &&
                     reg_req.wdata[zv_pkg::BIT_FORCE_SUPPORT]) begin
          platform_video_support_flag[s] <= 1'b1;
        end
      end

      // Per-socket enable in socket control
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          socket_video_port_enable[s] <= zv_pkg::SOCKET_ENABLE_RESET;
        end else if (clk_en && sel_sock[s] && sock_control_hit &&
                     reg_req.byte_en[1]) begin
          socket_video_port_enable[s] <=
            reg_req.wdata[zv_pkg::BIT_SOCKET_ENABLE];
        end
      end

      // Address pins: high lines float in video mode, low lines stay driven
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          card_addr_out[s] <= '0;
          card_addr_hi_oe[s] <= 1'b0;
          card_addr_lo_oe[s] <= 1'b0;
        end else if (clk_en) begin
          card_addr_out[s] <= core_addr[s];
          card_addr_hi_oe[s] <= core_addr_drive[s] &
                                ~effective_enable[s];
          card_addr_lo_oe[s] <= core_addr_drive[s];
        end
      end
    end
  endgenerate

  assign video_port_in_use = |effective_enable;

  // Read data mux; unmapped offsets read as zero
  always_comb begin
    rdata_next = '0;
    rvalid_next = reg_req.read;
    if (reg_req.read) begin
      if (reg_req.space == zv_pkg::SPACE_CONFIG) begin
        if (cfg_card_control_hit) begin
          rdata_next[7:0] = card_control_reg[reg_req.socket];
        end else if (cfg_diagnostic_hit) begin
          rdata_next[7:0] = diagnostic_control_reg[reg_req.socket];
        end
      end else begin
        if (sock_present_hit) begin
          rdata_next[zv_pkg::BIT_PLATFORM_SUPPORT] =
            platform_video_support_flag[reg_req.socket];
        end else if (sock_control_hit) begin
          rdata_next[zv_pkg::BIT_IN_USE] = video_port_in_use;
          rdata_next[zv_pkg::BIT_MODEL_CAPABLE] =
            standard_video_model_capable[reg_req.socket];
          rdata_next[zv_pkg::BIT_SOCKET_ENABLE] =
            socket_video_port_enable[reg_req.socket];
        end
      end
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rsp <= '0;
    end else if (clk_en) begin
      reg_rsp.valid <= rvalid_next;
      reg_rsp.rdata <= rdata_next;
    end
  end

  video_select_decode u_decode (
    .enable(effective_enable[1:0]),
    .prefer_socket1(prefer_socket1),
    .select0_n(decode_select0_n),
    .select1_n(decode_select1_n),
    .active(decode_active)
  );

  // Registered select and status outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      socket0_video_select_n <= 1'b1;
      socket1_video_select_n <= 1'b1;
      video_port_active_out <= 1'b0;
    end else if (clk_en) begin
      socket0_video_select_n <= decode_select0_n;
      socket1_video_select_n <= decode_select1_n;
      video_port_active_out <= decode_active;
    end
  end

endmodule
`default_nettype wire

// ===== bench/zv_bus_drivers.sv
// Model of the external three-state video bus drivers and source switch
`default_nettype none
module zv_bus_drivers (
  input wire logic socket0_video_select_n,
  input wire logic socket1_video_select_n,
  input wire logic video_port_active_out,
  output logic [1:0] bus_source,
  output logic contention
);
  timeunit 1ns;
  timeprecision 1ps;
  // Socket drivers open on low selects, third source while status is low
  always_comb begin
    bus_source = 2'h0;
    if (!socket0_video_select_n) begin
      bus_source = 2'h1;
    end
    if (!socket1_video_select_n) begin
      bus_source = 2'h2;
    end
    if (!video_port_active_out) begin
      bus_source = 2'h3;
    end
    contention = ({1'h0, !socket0_video_select_n} +
      {1'h0, !socket1_video_select_n} + {1'h0, !video_port_active_out}) > 2'h1;
  end
endmodule
`default_nettype wire

// ===== bench/zv_monitor.sv
// Assertion checker for the zoomed-video port control
`default_nettype none
module zv_monitor #(
  parameter int NUM_SOCKETS = 2,
  parameter int CARD_ADDR_W = 26
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire zv_pkg::reg_req_s reg_req,
  input wire zv_pkg::reg_rsp_s reg_rsp,
  input wire logic [NUM_SOCKETS-1:0][CARD_ADDR_W-1:0] core_addr,
  input wire logic [NUM_SOCKETS-1:0] core_addr_drive,
  input wire logic [NUM_SOCKETS-1:0][CARD_ADDR_W-1:0] card_addr_out,
  input wire logic [NUM_SOCKETS-1:0] card_addr_hi_oe,
  input wire logic [NUM_SOCKETS-1:0] card_addr_lo_oe,
  input wire logic socket0_video_select_n,
  input wire logic socket1_video_select_n,
  input wire logic video_port_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  one_select_a: assert property (
    socket0_video_select_n | socket1_video_select_n)
    else $error("both selects low");
  status_tracks_a: assert property (
    video_port_active_out == (!socket0_video_select_n |
    !socket1_video_select_n)) else $error("status mismatch");
  low_drive_a: assert property (clk_en && !reset |=>
    card_addr_lo_oe == $past(core_addr_drive)) else $error("low oe wrong");
  addr_copy_a: assert property (clk_en && !reset |=>
    card_addr_out == $past(core_addr)) else $error("address not copied");
  hi_under_lo_a: assert property (
    (card_addr_hi_oe & ~card_addr_lo_oe) == '0) else $error("high oe alone");
  sock0_float_a: assert property (
    !socket0_video_select_n |-> !card_addr_hi_oe[0])
    else $error("socket 0 high address driven");
  sock1_float_a: assert property (
    !socket1_video_select_n |-> !card_addr_hi_oe[1])
    else $error("socket 1 high address driven");
  read_answer_a: assert property (clk_en && !reset |=>
    reg_rsp.valid == $past(reg_req.read)) else $error("read answer wrong");
endmodule
bind zoomed_video_port_control zv_monitor #(.NUM_SOCKETS(NUM_SOCKETS),
  .CARD_ADDR_W(CARD_ADDR_W)) zv_monitor_i (.clk(clk), .reset(reset),
  .clk_en(clk_en), .reg_req(reg_req), .reg_rsp(reg_rsp),
  .core_addr(core_addr), .core_addr_drive(core_addr_drive),
  .card_addr_out(card_addr_out), .card_addr_hi_oe(card_addr_hi_oe),
  .card_addr_lo_oe(card_addr_lo_oe),
  .socket0_video_select_n(socket0_video_select_n),
  .socket1_video_select_n(socket1_video_select_n),
  .video_port_active_out(video_port_active_out));
`default_nettype wire

// ===== bench/zoomed_video_port_control_tb.sv
// Self-checking bench for the zoomed-video port control
`default_nettype none
module zoomed_video_port_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam zv_pkg::space_e CF = zv_pkg::SPACE_CONFIG;
  localparam zv_pkg::space_e SK = zv_pkg::SPACE_SOCKET;
  logic clk;
  logic reset;
  logic clk_en;
  zv_pkg::reg_req_s reg_req;
  zv_pkg::reg_rsp_s reg_rsp;
  logic [1:0][25:0] core_addr;
  logic [1:0] core_addr_drive;
  logic [1:0] card_addr_hi_oe;
  logic [1:0] card_addr_lo_oe;
  logic socket0_video_select_n;
  logic socket1_video_select_n;
  logic video_port_active_out;
  logic [1:0] bus_source;
  logic contention;
  logic a, b, p, s0, s1;
  int fails;
  int n_checks;
  zoomed_video_port_control zoomed_video_port_control_i (.clk(clk),
    .reset(reset), .clk_en(clk_en), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .core_addr(core_addr), .core_addr_drive(core_addr_drive),
    .card_addr_out(), .card_addr_hi_oe(card_addr_hi_oe),
    .card_addr_lo_oe(card_addr_lo_oe),
    .socket0_video_select_n(socket0_video_select_n),
    .socket1_video_select_n(socket1_video_select_n),
    .video_port_active_out(video_port_active_out));
  zv_bus_drivers zv_bus_drivers_i (
    .socket0_video_select_n(socket0_video_select_n),
    .socket1_video_select_n(socket1_video_select_n),
    .video_port_active_out(video_port_active_out),
    .bus_source(bus_source), .contention(contention));
  task automatic end_of_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  // Pins settle one edge after the write that changes an enable; the check waits two
  task automatic chk_pins(input logic [9:0] exp);
    logic [9:0] got;
    repeat (2) @(posedge clk);
    #1;
    got = {socket0_video_select_n, socket1_video_select_n,
      video_port_active_out, card_addr_hi_oe, card_addr_lo_oe,
      bus_source, contention};
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t pins got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic w, input zv_pkg::space_e sp,
      input logic sk, input logic [7:0] off, input logic [31:0] d,
      input logic [3:0] be);
    @(posedge clk);
    reg_req <= '{write: w, read: !w, space: sp, socket: sk, offset: off,
      wdata: d, byte_en: be};
    @(posedge clk);
    reg_req <= '0;
    #1;
  endtask
  task automatic rd(input zv_pkg::space_e sp, input logic sk,
      input logic [7:0] off, input logic [31:0] exp);
    access(1'h0, sp, sk, off, 32'h0, 4'h0);
    chk_reg({reg_rsp.valid, reg_rsp.rdata}, {1'h1, exp});
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    end_of_test();
  end
  initial begin
    reset = 1'h1;
    clk_en = 1'h1;
    reg_req = '0;
    core_addr = {26'h1234567, 26'h3ABCDE5};
    core_addr_drive = 2'h3;
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    for (int k = 0; k < 8; k++) begin
      {p, b, a} = k[2:0];
      access(1'h1, CF, 1'h0, 8'h91, {25'h0, a, p, 5'h0}, 4'h1);
      access(1'h1, CF, 1'h1, 8'h91, {25'h0, b, 6'h0}, 4'h1);
      s0 = !(a && (!p || !b));
      s1 = !(b && (p || !a));
      chk_pins({s0, s1, a | b, ~{b, a}, 2'h3,
        !s0 ? 2'h1 : (!s1 ? 2'h2 : 2'h3), 1'h0});
      rd(SK, 1'h0, 8'h10, {20'h0, a | b, 2'h2, 9'h0});
    end
    $display("test decode done");
    access(1'h1, CF, 1'h0, 8'h91, 32'h0, 4'h1);
    access(1'h1, CF, 1'h1, 8'h91, 32'h0, 4'h1);
    rd(SK, 1'h1, 8'h10, 32'h400);
    access(1'h1, SK, 1'h1, 8'h0C, 32'h0800_0000, 4'h7);
    rd(SK, 1'h1, 8'h08, 32'h0);
    access(1'h1, SK, 1'h1, 8'h0C, 32'h0800_0000, 4'h8);
    rd(SK, 1'h1, 8'h08, 32'h0800_0000);
    rd(SK, 1'h0, 8'h08, 32'h0);
    rd(SK, 1'h1, 8'h0C, 32'h0);
    access(1'h1, SK, 1'h1, 8'h10, 32'h200, 4'h2);
    chk_pins({1'h1, 1'h0, 1'h1, 2'h1, 2'h3, 2'h2, 1'h0});
    rd(SK, 1'h1, 8'h10, 32'hE00);
    access(1'h1, CF, 1'h1, 8'h93, 32'h1, 4'h1);
    chk_pins({1'h1, 1'h1, 1'h0, 2'h3, 2'h3, 2'h3, 1'h0});
    rd(SK, 1'h1, 8'h10, 32'h200);
    rd(CF, 1'h1, 8'h93, 32'h1);
    access(1'h1, CF, 1'h1, 8'h91, 32'h40, 4'h1);
    chk_pins({1'h1, 1'h0, 1'h1, 2'h1, 2'h3, 2'h2, 1'h0});
    rd(SK, 1'h0, 8'h14, 32'h0);
    rd(CF, 1'h0, 8'h92, 32'h0);
    @(posedge clk);
    clk_en <= 1'h0;
    access(1'h1, CF, 1'h0, 8'h91, 32'h40, 4'h1);
    @(posedge clk);
    clk_en <= 1'h1;
    chk_pins({1'h1, 1'h0, 1'h1, 2'h1, 2'h3, 2'h2, 1'h0});
    rd(CF, 1'h0, 8'h91, 32'h0);
    $display("test model done");
    @(posedge clk);
    reset <= 1'h1;
    chk_pins({1'h1, 1'h1, 1'h0, 2'h0, 2'h0, 2'h3, 1'h0});
    @(posedge clk);
    reset <= 1'h0;
    rd(SK, 1'h1, 8'h08, 32'h0);
    $display("test reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
